// file: logic/wup_defines.vh
// register map, field positions, reset values and matcher constants of the wake-up pattern bank
`ifndef WUP_DEFINES_VH
`define WUP_DEFINES_VH

// register byte offsets
`define WUP_OFS_WAKE_CTRL       8'h48
`define WUP_OFS_START_OFFSETS   8'h4C
`define WUP_OFS_PAT0_CRC        8'h50
`define WUP_OFS_PAT1_CRC        8'h54
`define WUP_OFS_PAT2_CRC        8'h58
`define WUP_OFS_PAT3_CRC        8'h5C
`define WUP_OFS_PAT0_MASK_LOW   8'h60
`define WUP_OFS_PAT0_MASK_HIGH  8'h64
`define WUP_OFS_PAT1_MASK_LOW   8'h68
`define WUP_OFS_PAT1_MASK_HIGH  8'h6C
`define WUP_OFS_PAT2_MASK_LOW   8'h70
`define WUP_OFS_PAT2_MASK_HIGH  8'h74
`define WUP_OFS_PAT3_MASK_LOW   8'h78
`define WUP_OFS_PAT3_MASK_HIGH  8'h7C
`define WUP_OFS_IRQ_STATUS      8'h80
`define WUP_OFS_IRQ_MASK        8'h84
`define WUP_OFS_POWER_CAP       8'hDC
`define WUP_OFS_PM_CTRL         8'hE0

// reset values
`define WUP_RST_PAT0_CRC        32'hFFFFFFFF
`define WUP_RST_PAT1_CRC        32'hFFFFFFFF
`define WUP_RST_PAT2_CRC        32'h0FFFFFFF
`define WUP_RST_PAT3_CRC        32'hFFFFFFFF
`define WUP_RST_MASK            32'h00000000

// capability word fields
`define WUP_CAP_WAKE_SUPPORT    5'h0B
`define WUP_CAP_STATE2_SUP      1'b0
`define WUP_CAP_STATE1_SUP      1'b1
`define WUP_CAP_DEV_INIT        1'b0
`define WUP_CAP_NEEDS_BUS_CLK   1'b0
`define WUP_CAP_REVISION        3'h1
`define WUP_CAP_NEXT_ITEM       8'h00
`define WUP_CAP_IDENTIFIER      8'h01

// wake control word fields
`define WUP_CTRL_FLAG_LSB       17
`define WUP_CTRL_DET_EN_BIT     1

// power control word fields
`define WUP_PM_STATUS_BIT       15
`define WUP_PM_ENABLE_BIT       8
`define WUP_PM_STATE_D0         2'h0
`define WUP_PM_STATE_D3HOT      2'h3
`define WUP_PM_STATE_BAD        2'h2

// ethernet crc-32, reflected form
`define WUP_CRC_POLY            32'hEDB88320
`define WUP_CRC_INIT            32'hFFFFFFFF

`endif

// file: logic/wup_sticky.v
// sticky flag bank: set beats clear in the same cycle
`timescale 1ns/1ps
module wup_sticky #(
   parameter WIDTH = 4
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] setBits,
   input  wire [WIDTH-1:0] clrBits,
   output reg  [WIDTH-1:0] flags_q
);

   // clear first, then set, so an event never falls into the clear cycle
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         flags_q <= {WIDTH{1'b0}};
      end else begin
         flags_q <= (flags_q & ~clrBits) | setBits;
      end
   end

endmodule

// file: logic/wup_matcher.v
// one wake-up pattern matcher: masked crc over a 64-byte window from an offset
`timescale 1ns/1ps
`include "wup_defines.vh"
module wup_matcher #(
   parameter POS_W = 11
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire             frameStart,
   input  wire             byteValid,
   input  wire [7:0]       byteData,
   input  wire [POS_W-1:0] bytePos,
   input  wire             frameEnd,
   input  wire [7:0]       startOffset,
   input  wire [63:0]      maskWord,
   input  wire [31:0]      matchValue,
   output reg              matchPulse_q
);

   reg  [31:0]      crc_q;
   reg  [63:0]      seen_q;
   wire [POS_W-1:0] relPos;
   wire             inWindow;

   // one byte step of the reflected ethernet crc
   function [31:0] crcByte;
      input [31:0] c;
      input [7:0]  d;
      integer      i;
      reg   [31:0] r;
      begin
         r = c ^ {24'h000000, d};
         for (i = 0; i < 8; i = i + 1) begin
            r = r[0] ? ((r >> 1) ^ `WUP_CRC_POLY) : (r >> 1);
         end
         crcByte = r;
      end
   endfunction

   // window position relative to the pattern offset
   assign relPos   = bytePos - {{(POS_W-8){1'b0}}, startOffset};
   assign inWindow = (bytePos >= {{(POS_W-8){1'b0}}, startOffset})
                   && (relPos < 64);

   // crc runs only over selected bytes; seen marks which window bytes arrived
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         crc_q        <= `WUP_CRC_INIT;
         seen_q       <= 64'h0000000000000000;
         matchPulse_q <= 1'b0;
      end else begin
         matchPulse_q <= 1'b0;
         if (frameStart) begin
            crc_q  <= `WUP_CRC_INIT;
            seen_q <= 64'h0000000000000000;
         end else if (byteValid && inWindow) begin
            seen_q[relPos[5:0]] <= 1'b1;
            if (maskWord[relPos[5:0]]) begin          // see R2, see R3
               crc_q <= crcByte(crc_q, byteData);     // see R18
            end
         end
         // short frame never reaches every selected byte, so it fails
         if (frameEnd) begin
            matchPulse_q <= (maskWord != 64'h0000000000000000)
                         && ((seen_q & maskWord) == maskWord)   // see R19
                         && ((~crc_q) == matchValue);           // see R18
         end
      end
   end

endmodule

// file: logic/wup_pattern_bank.v
// wake-up pattern register bank with ahb-lite slave, matchers and wake output
//
// Functional notes
// R1: patterns 1 to 3 each own a 32-bit read/write crc match value.
// R2: first mask word bit n selects frame byte n, n 0..31.
// R3: second mask word bit n selects frame byte 32+n, up to 63.
// R4: four patterns 0..3, each with two read/write mask words, 64 bytes.
// R5: capability bits 31..27 read 01011, wake from D3 hot, D1, D0.
// R6: capability bit 26 reads 0, no D2 state.
// R7: capability bit 25 reads 1, D1 state supported.
// R8: capability bit 21 reads 0, no special init needed.
// R9: capability bit 19 reads 0, wake needs no bus clock.
// R10: capability revision bits 18..16 read 001.
// R11: next item pointer bits 15..8 read zero.
// R12: capability identifier bits 7..0 read 01 hex.
// R13: reserved capability bits read zero; writes to capability ignored.
// R14: enabled detector match sets pattern flag; write 1 clears, 0 keeps.
// R15: each pattern has an 8-bit start offset into the frame.
// R16: wake signal active while wake status and wake enable both set.
// R17: pattern 0 crc match value, read/write, resets to all ones.
// R18: match means masked-byte crc-32 from offset equals stored value.
// R19: frame too short for highest selected byte does not match.
`timescale 1ns/1ps
`include "wup_defines.vh"
module wup_pattern_bank #(
   parameter POS_W = 11
) (
   input  wire        sys_clk,
   input  wire        rst_n,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // receive byte stream, same clock domain
   input  wire        frameStart,
   input  wire        byteValid,
   input  wire [7:0]  byteData,
   input  wire        frameEnd,
   // wake and interrupt
   output reg         wake_signal_n,
   output reg         irq
);

   // address phase capture
   reg         wrPend_q;
   reg         rdPend_q;
   reg  [7:0]  addr_q;

   // software registers
   reg  [31:0] pat0Crc_q;
   reg  [31:0] pat1Crc_q;
   reg  [31:0] pat2Crc_q;
   reg  [31:0] pat3Crc_q;
   reg  [31:0] maskLow_q  [0:3];
   reg  [31:0] maskHigh_q [0:3];
   reg  [31:0] offsets_q;
   reg         detEnable_q;
   reg         wakeEnable_q;
   reg  [1:0]  pmState_q;
   reg  [3:0]  irqMask_q;
   reg  [POS_W-1:0] bytePos_q;

   wire [3:0]  matchPulse;
   wire [3:0]  flags;
   wire [3:0]  irqStatus;
   wire        wakeStatus;
   wire        addrPhase;
   wire        wrCtrl;
   wire        wrPm;
   wire        leaveD3;
   wire [3:0]  flagSet;
   wire [3:0]  flagClr;
   wire [3:0]  irqClr;
   wire [31:0] capWord;
   wire [31:0] rdValue;
   integer     k;

   assign addrPhase = hsel && htrans[1] && hready;
   assign wrCtrl    = wrPend_q && (addr_q == `WUP_OFS_WAKE_CTRL);
   assign wrPm      = wrPend_q && (addr_q == `WUP_OFS_PM_CTRL);

   // hot D3 to D0 drops the enables, as the power state machine requires
   assign leaveD3 = wrPm && (pmState_q == `WUP_PM_STATE_D3HOT)
                 && (hwdata[1:0] == `WUP_PM_STATE_D0);

   // capability word is pure wiring, no storage to write
   assign capWord = {`WUP_CAP_WAKE_SUPPORT,                 // see R5
                     `WUP_CAP_STATE2_SUP,                   // see R6
                     `WUP_CAP_STATE1_SUP,                   // see R7
                     3'h0,                                  // see R13
                     `WUP_CAP_DEV_INIT,                     // see R8
                     1'b0,                                  // see R13
                     `WUP_CAP_NEEDS_BUS_CLK,                // see R9
                     `WUP_CAP_REVISION,                     // see R10
                     `WUP_CAP_NEXT_ITEM,                    // see R11
                     `WUP_CAP_IDENTIFIER};                  // see R12

   // ahb address phase: writes go zero-wait, reads take one wait state
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         addr_q   <= 8'h00;
      end else begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         if (addrPhase) begin
            wrPend_q <= hwrite;
            rdPend_q <= ~hwrite;
            addr_q   <= (haddr[31:8] == 24'h000000) ? {haddr[7:2], 2'b00} : 8'hFF;
         end
      end
   end

   // ready drops for the first read data cycle so read data come from a flop
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (addrPhase && !hwrite) begin
            hreadyout <= 1'b0;
         end else begin
            hreadyout <= 1'b1;
         end
      end
   end

   // read mux, unmapped addresses read zero
   assign rdValue =
        (addr_q == `WUP_OFS_WAKE_CTRL)      ? {11'h000, flags, 15'h0000, detEnable_q, 1'b0}
      : (addr_q == `WUP_OFS_START_OFFSETS)  ? offsets_q
      : (addr_q == `WUP_OFS_PAT0_CRC)       ? pat0Crc_q
      : (addr_q == `WUP_OFS_PAT1_CRC)       ? pat1Crc_q
      : (addr_q == `WUP_OFS_PAT2_CRC)       ? pat2Crc_q
      : (addr_q == `WUP_OFS_PAT3_CRC)       ? pat3Crc_q
      : (addr_q == `WUP_OFS_PAT0_MASK_LOW)  ? maskLow_q[0]
      : (addr_q == `WUP_OFS_PAT0_MASK_HIGH) ? maskHigh_q[0]
      : (addr_q == `WUP_OFS_PAT1_MASK_LOW)  ? maskLow_q[1]
      : (addr_q == `WUP_OFS_PAT1_MASK_HIGH) ? maskHigh_q[1]
      : (addr_q == `WUP_OFS_PAT2_MASK_LOW)  ? maskLow_q[2]
      : (addr_q == `WUP_OFS_PAT2_MASK_HIGH) ? maskHigh_q[2]
      : (addr_q == `WUP_OFS_PAT3_MASK_LOW)  ? maskLow_q[3]
      : (addr_q == `WUP_OFS_PAT3_MASK_HIGH) ? maskHigh_q[3]
      : (addr_q == `WUP_OFS_IRQ_STATUS)     ? {28'h0000000, irqStatus}
      : (addr_q == `WUP_OFS_IRQ_MASK)       ? {28'h0000000, irqMask_q}
      : (addr_q == `WUP_OFS_POWER_CAP)      ? capWord
      : (addr_q == `WUP_OFS_PM_CTRL)        ? {16'h0000, wakeStatus, 6'h00, wakeEnable_q,
                                               6'h00, pmState_q}
      : 32'h00000000;

   // read data registered in the wait cycle, cleared when idle
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (rdPend_q) begin
         hrdata <= rdValue;
      end else begin
         hrdata <= 32'h00000000;
      end
   end

   // crc match values, whole-word writes in the data phase
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         pat0Crc_q <= `WUP_RST_PAT0_CRC;                    // see R17
         pat1Crc_q <= `WUP_RST_PAT1_CRC;
         pat2Crc_q <= `WUP_RST_PAT2_CRC;
         pat3Crc_q <= `WUP_RST_PAT3_CRC;
      end else if (wrPend_q) begin
         case (addr_q)
            `WUP_OFS_PAT0_CRC: begin
               pat0Crc_q <= hwdata;                         // see R17
            end
            `WUP_OFS_PAT1_CRC: begin
               pat1Crc_q <= hwdata;                         // see R1
            end
            `WUP_OFS_PAT2_CRC: begin
               pat2Crc_q <= hwdata;                         // see R1
            end
            `WUP_OFS_PAT3_CRC: begin
               pat3Crc_q <= hwdata;                         // see R1
            end
            default: begin
               pat0Crc_q <= pat0Crc_q;
            end
         endcase
      end
   end

   // mask word pairs, pattern index from address bits 4:3
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         for (k = 0; k < 4; k = k + 1) begin
            maskLow_q[k]  <= `WUP_RST_MASK;
            maskHigh_q[k] <= `WUP_RST_MASK;
         end
      end else if (wrPend_q && (addr_q >= `WUP_OFS_PAT0_MASK_LOW)
                   && (addr_q <= `WUP_OFS_PAT3_MASK_HIGH)) begin
         if (addr_q[2]) begin
            maskHigh_q[addr_q[4:3]] <= hwdata;              // see R3, see R4
         end else begin
            maskLow_q[addr_q[4:3]]  <= hwdata;              // see R2, see R4
         end
      end
   end

   // offsets, detector enable, power state and wake enable
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         offsets_q    <= 32'h00000000;
         detEnable_q  <= 1'b0;
         wakeEnable_q <= 1'b0;
         pmState_q    <= `WUP_PM_STATE_D0;
         irqMask_q    <= 4'h0;
      end else begin
         if (wrPend_q && (addr_q == `WUP_OFS_START_OFFSETS)) begin
            offsets_q <= hwdata;                            // see R15
         end
         if (wrPend_q && (addr_q == `WUP_OFS_IRQ_MASK)) begin
            irqMask_q <= hwdata[3:0];
         end
         if (leaveD3) begin
            detEnable_q  <= 1'b0;
            wakeEnable_q <= 1'b0;
         end else begin
            if (wrCtrl) begin
               detEnable_q <= hwdata[`WUP_CTRL_DET_EN_BIT];
            end
            if (wrPm) begin
               wakeEnable_q <= hwdata[`WUP_PM_ENABLE_BIT];
            end
         end
         // the undefined state code is refused, state stays put
         if (wrPm && (hwdata[1:0] != `WUP_PM_STATE_BAD)) begin
            pmState_q <= hwdata[1:0];
         end
      end
   end

   // byte position within the frame, saturates on very long frames
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         bytePos_q <= {POS_W{1'b0}};
      end else if (frameStart) begin
         bytePos_q <= {POS_W{1'b0}};
      end else if (byteValid && (bytePos_q != {POS_W{1'b1}})) begin
         bytePos_q <= bytePos_q + {{(POS_W-1){1'b0}}, 1'b1};
      end
   end

   // four matchers share the byte stream, each with its own window
   wup_matcher #(.POS_W(POS_W)) matcher0 (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .frameStart   (frameStart),
      .byteValid    (byteValid),
      .byteData     (byteData),
      .bytePos      (bytePos_q),
      .frameEnd     (frameEnd),
      .startOffset  (offsets_q[7:0]),
      .maskWord     ({maskHigh_q[0], maskLow_q[0]}),
      .matchValue   (pat0Crc_q),
      .matchPulse_q (matchPulse[0])
   );
   wup_matcher #(.POS_W(POS_W)) matcher1 (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .frameStart   (frameStart),
      .byteValid    (byteValid),
      .byteData     (byteData),
      .bytePos      (bytePos_q),
      .frameEnd     (frameEnd),
      .startOffset  (offsets_q[15:8]),
      .maskWord     ({maskHigh_q[1], maskLow_q[1]}),
      .matchValue   (pat1Crc_q),
      .matchPulse_q (matchPulse[1])
   );
   wup_matcher #(.POS_W(POS_W)) matcher2 (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .frameStart   (frameStart),
      .byteValid    (byteValid),
      .byteData     (byteData),
      .bytePos      (bytePos_q),
      .frameEnd     (frameEnd),
      .startOffset  (offsets_q[23:16]),
      .maskWord     ({maskHigh_q[2], maskLow_q[2]}),
      .matchValue   (pat2Crc_q),
      .matchPulse_q (matchPulse[2])
   );
   wup_matcher #(.POS_W(POS_W)) matcher3 (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .frameStart   (frameStart),
      .byteValid    (byteValid),
      .byteData     (byteData),
      .bytePos      (bytePos_q),
      .frameEnd     (frameEnd),
      .startOffset  (offsets_q[31:24]),
      .maskWord     ({maskHigh_q[3], maskLow_q[3]}),
      .matchValue   (pat3Crc_q),
      .matchPulse_q (matchPulse[3])
   );

   // received flags: set by enabled matches, cleared by write-one or wake status clear
   assign flagSet = detEnable_q ? matchPulse : 4'h0;                 // see R14
   assign flagClr = (wrCtrl ? hwdata[`WUP_CTRL_FLAG_LSB+3:`WUP_CTRL_FLAG_LSB] : 4'h0)
                  | ((wrPm && hwdata[`WUP_PM_STATUS_BIT]) ? 4'hF : 4'h0);

   wup_sticky #(.WIDTH(4)) flagBank (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .setBits (flagSet),
      .clrBits (flagClr),
      .flags_q (flags)
   );

   // wake status follows any enabled match, cleared by writing one
   wup_sticky #(.WIDTH(1)) wakeBank (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .setBits (|flagSet),
      .clrBits (wrPm && hwdata[`WUP_PM_STATUS_BIT]),
      .flags_q (wakeStatus)
   );

   // interrupt status clears when its read data are sampled
   assign irqClr = (rdPend_q && (addr_q == `WUP_OFS_IRQ_STATUS)) ? 4'hF : 4'h0;

   wup_sticky #(.WIDTH(4)) irqBank (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .setBits (matchPulse),
      .clrBits (irqClr),
      .flags_q (irqStatus)
   );

   // outputs registered; wake is low active
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         wake_signal_n <= 1'b1;
         irq           <= 1'b0;
      end else begin
         wake_signal_n <= ~(wakeStatus && wakeEnable_q);    // see R16
         irq           <= |(irqStatus & irqMask_q);
      end
   end

endmodule

// file: tb/wup_bank_assertions.sv
// assertion checker for the wake-up pattern bank register port
`timescale 1ns/1ps
module wup_bank_assertions #(
   parameter POS_W = 11
) (
   input wire        sys_clk,
   input wire        rst_n,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        wake_signal_n,
   input wire        irq
);
   // capability word read accepted at this edge
   wire capRd = hsel & htrans[1] & hready & ~hwrite & (haddr == 32'h000000DC);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_wake_support : assert property (capRd |-> ##2 hrdata[31:27] == 5'h0B)
      else $error("wake support field wrong");
   a_no_state2 : assert property (capRd |=> !hreadyout ##1 (hreadyout && !hrdata[26]))
      else $error("state 2 support bit set");
   a_state1_sup : assert property (capRd ##2 hreadyout |-> hrdata[25])
      else $error("state 1 support bit clear");
   a_no_init_seq : assert property (capRd |-> ##2 hrdata[21] == 1'b0)
      else $error("device init bit set");
   a_no_bus_clk : assert property (capRd |-> ##2 !hrdata[19])
      else $error("bus clock bit set");
   a_cap_revision : assert property (capRd |-> ##2 hrdata[18:16] == 3'h1)
      else $error("revision field wrong");
   a_next_item : assert property (capRd ##2 hreadyout |-> hrdata[15:8] == 8'h00)
      else $error("next item pointer not zero");
   a_cap_ident : assert property (capRd |-> ##2 hrdata[7:0] == 8'h01)
      else $error("capability identifier wrong");
   a_cap_reserved : assert property (capRd |-> ##2 {hrdata[24:22], hrdata[20]} == 4'h0)
      else $error("reserved capability bits set");

   // main scenarios reached
   c_cap_read : cover property (capRd ##2 hreadyout);
   c_wake_on : cover property ($fell(wake_signal_n));
   c_irq_on : cover property ($rose(irq));
endmodule

bind wup_pattern_bank wup_bank_assertions #(.POS_W(POS_W)) i_wup_bank_assertions (
   .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .wake_signal_n(wake_signal_n), .irq(irq));

// file: tb/wup_host_model.sv
// host software model: single-word ahb-lite master
`timescale 1ns/1ps
module wup_host_model (
   input  wire        sys_clk,
   input  wire        hready,
   input  wire [31:0] hrdata,
   output reg         hsel,
   output reg  [31:0] haddr,
   output reg  [1:0]  htrans,
   output reg         hwrite,
   output reg  [2:0]  hsize,
   output reg  [31:0] hwdata
);
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end

   // entered just after an edge; each phase held until hready is sampled high
   task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      hsize  <= 3'h2;
      hwdata <= ~hwdata;   // stale data must not look valid
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      if (wr) hwdata <= d;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      rd = hrdata;
   endtask
endmodule

// file: tb/wup_pattern_bank_test.sv
// self-checking bench for the wake-up pattern bank
`timescale 1ns/1ps
module wup_pattern_bank_test;
   reg         sys_clk;
   reg         rst_n;
   reg         frameStart;
   reg         byteValid;
   reg  [7:0]  byteData;
   reg         frameEnd;
   wire        hsel;
   wire [31:0] haddr;
   wire [1:0]  htrans;
   wire        hwrite;
   wire [2:0]  hsize;
   wire [31:0] hwdata;
   wire [31:0] hrdata;
   wire        hreadyout;
   wire        hresp;
   wire        wake_signal_n;
   wire        irq;
   integer     errTotal;
   integer     checksDone;
   integer     cycles;
   integer     i;

   wup_host_model i_wup_host_model (
      .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   wup_pattern_bank i_wup_pattern_bank (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frameStart(frameStart),
      .byteValid(byteValid), .byteData(byteData), .frameEnd(frameEnd),
      .wake_signal_n(wake_signal_n), .irq(irq));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         errTotal = errTotal + 1;
         print_verdict;
      end
   end

   // byte value at frame position k
   function [7:0] dat(input integer k);
      dat = 8'(k * 29 + 5);
   endfunction

   // expected stored value: complemented reflected crc over selected bytes
   function [31:0] crcOf(input [63:0] m);
      reg [31:0] c;
      integer    k;
      integer    b;
      c = 32'hFFFFFFFF;
      for (k = 0; k < 64; k = k + 1) begin
         if (m[k]) begin
            c = c ^ {24'h000000, dat(k)};
            for (b = 0; b < 8; b = b + 1)
               c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
         end
      end
      crcOf = ~c;
   endfunction

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone = checksDone + 1;
      if (seen !== exp) begin
         errTotal = errTotal + 1;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] unused;
      i_wup_host_model.xfer(1'b1, a, d, unused);
   endtask

   task rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] got;
      i_wup_host_model.xfer(1'b0, a, 32'h0, got);
      chk(got, exp);
      chk({31'h0, hresp}, 32'h0);   // response must stay okay
   endtask

   // frame stream: start pulse, n bytes back to back, end pulse
   task sendFrame(input integer n);
      integer k;
      frameStart <= 1'b1;
      @(posedge sys_clk);
      frameStart <= 1'b0;
      for (k = 0; k < n; k = k + 1) begin
         byteValid <= 1'b1;
         byteData  <= dat(k);
         @(posedge sys_clk);
      end
      byteValid <= 1'b0;
      byteData  <= ~byteData;   // idle line must not repeat the last byte
      frameEnd  <= 1'b1;
      @(posedge sys_clk);
      frameEnd  <= 1'b0;
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      errTotal   = 0;
      checksDone = 0;
      cycles     = 0;
      rst_n      = 1'b0;
      frameStart = 1'b0;
      byteValid  = 1'b0;
      byteData   = 8'h00;
      frameEnd   = 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);

      // reset values of crc and mask words, then the capability word
      for (i = 0; i < 11; i = i + 1)
         rd(32'h54 + 4 * i, i == 1 ? 32'h0FFFFFFF : (i < 3 ? 32'hFFFFFFFF : 32'h0));
      rd(32'hDC, 32'h5A010001);
      rd(32'h50, 32'hFFFFFFFF);
      rd(32'h4C, 32'h0);
      $display("reset values done");

      // back-to-back write then read of pattern 1 to 3 crc and all mask words, capability write ignored
      for (i = 0; i < 11; i = i + 1) begin
         wr(32'h54 + 4 * i, 32'hA5C30F00 ^ (32'h1 << (i * 3)));
         rd(32'h54 + 4 * i, 32'hA5C30F00 ^ (32'h1 << (i * 3)));
      end
      wr(32'hDC, 32'h0);
      rd(32'hDC, 32'h5A010001);
      wr(32'h154, 32'hFFFFFFFF);
      rd(32'h154, 32'h0);
      rd(32'h54, 32'hA5C30F01);
      $display("read-write access done");

      // pattern 0 byte 5 via offset, pattern 1 bytes 0 and 2, pattern 2 byte 32,
      // pattern 3 byte 63 never arrives
      wr(32'h4C, 32'h5);
      rd(32'h4C, 32'h5);
      wr(32'h50, crcOf(64'h0000000000000020));
      wr(32'h54, crcOf(64'h0000000000000005));
      wr(32'h58, crcOf(64'h0000000100000000));
      wr(32'h5C, crcOf(64'h8000000000000000));
      for (i = 0; i < 8; i = i + 1)
         wr(32'h60 + 4 * i, (i == 0 || i == 5) ? 32'h1
                            : (i == 2 ? 32'h5 : (i == 7 ? 32'h80000000 : 32'h0)));
      wr(32'h48, 32'h2);
      wr(32'h84, 32'h8);   // only pattern 3 unmasked, so no interrupt yet
      wr(32'hE0, 32'h100);
      sendFrame(40);
      repeat (6) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, wake_signal_n}, 32'h0);
      rd(32'h48, 32'h000E0002);
      wr(32'h84, 32'hF);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h1);
      rd(32'h80, 32'h7);
      rd(32'h80, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("pattern match done");

      // flag write-one-clear, then wake status clear releases the wake line
      wr(32'h48, 32'h2);
      rd(32'h48, 32'h000E0002);
      wr(32'h48, 32'h00040002);
      rd(32'h48, 32'h000A0002);
      chk({31'h0, wake_signal_n}, 32'h0);
      wr(32'hE0, 32'h8100);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, wake_signal_n}, 32'h1);
      rd(32'h48, 32'h2);
      rd(32'hE0, 32'h100);
      $display("flag and wake clear done");
      print_verdict;
   end
endmodule
